// ---- hw/limit_step_mapper.sv ----
// maps a limit word onto a supported hardware percentage step
`timescale 1ns/1ps
module limit_step_mapper #(
    parameter int MIN_S = 206,
    parameter int MAX_S = 232,
    parameter int STEP_S = 2,
    parameter bit ROUND_UP = 1'b1
) (
    input wire logic [15:0] value,
    input wire logic [15:0] base,
    output logic [vout_limit_pkg::STEP_W-1:0] step_out,
    output logic ok
);
    import vout_limit_pkg::*;

    localparam int NSTEPS = (MAX_S - MIN_S) / STEP_S + 1;

    ////////////////////////////////////////////////////////////////////////
    // scaled request and range bounds; base is 1.0 or the present target
    logic [31:0] scaled;
    logic [31:0] lo_bound;
    logic [31:0] hi_bound;
    assign scaled = 32'(value) * PCT_SCALE;
    assign lo_bound = 32'(MIN_S) * 32'(base);
    assign hi_bound = 32'(MAX_S) * 32'(base);
    // anything outside the supported span is refused, not clamped
    assign ok = (base != 16'h0000) && (scaled >= lo_bound) && (scaled <= hi_bound);

    ////////////////////////////////////////////////////////////////////////
    // pick first step at or above (round up) or last at or below (down)
    always_comb begin
        logic found;
        logic [31:0] lvl;
        found = 1'b0;
        lvl = 32'h0000_0000;
        step_out = STEP_W'(MIN_S);
        for (int k = 0; k < NSTEPS; k++) begin
            lvl = 32'(MIN_S + k * STEP_S) * 32'(base);
            if (ROUND_UP) begin
                if (!found && lvl >= scaled) begin
                    step_out = STEP_W'(MIN_S + k * STEP_S);
                    found = 1'b1;
                end
            end else if (lvl <= scaled) begin
                step_out = STEP_W'(MIN_S + k * STEP_S);
            end
        end
    end
endmodule : limit_step_mapper

// ---- hw/vout_limit_monitor.sv ----
// output-voltage warning and undervoltage fault limit registers and monitor
`timescale 1ns/1ps
module vout_limit_monitor (
    input wire logic clk,
    input wire logic rst_n,
    // command port from the host transport
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] rd_data,
    output logic rd_valid,
    // nonvolatile restore of the three limit words
    input wire logic nvm_load,
    input wire logic [15:0] nvm_ov_warn_value,
    input wire logic [15:0] nvm_uv_warn_value,
    input wire logic [15:0] nvm_uv_fault_value,
    // operating context
    input wire logic vout_mode_relative,
    input wire logic [15:0] vout_target,
    input wire logic [15:0] vout_sense,
    // outputs to the system
    output logic uv_fault,
    output logic uv_fault_event,
    output logic alert_n
);
    import vout_limit_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [15:0] limit_reg [NUM_LIMITS];
    logic [STEP_W-1:0] step_reg [NUM_LIMITS];
    logic [7:0] status_vout_reg;
    logic [7:0] status_vout_next;
    logic [7:0] status_cml_reg;
    logic [7:0] status_cml_next;
    logic armed_reg;
    logic uv_fault_reg;
    logic [15:0] rd_data_reg;
    logic rd_valid_reg;
    logic alert_n_reg;

    ////////////////////////////////////////////////////////////////////////
    // command decode
    logic wr_any;
    logic rd_any;
    logic clear_hit;
    logic [NUM_LIMITS-1:0] lim_hit;
    logic known_cmd;
    assign wr_any = cmd_valid && cmd_write;
    assign rd_any = cmd_valid && !cmd_write;
    assign lim_hit[IDX_OVW] = (cmd_code == CMD_OVERVOLTAGE_WARNING_LIMIT);
    assign lim_hit[IDX_UVW] = (cmd_code == CMD_UV_WARN_LIMIT);
    assign lim_hit[IDX_UVF] = (cmd_code == CMD_UV_FAULT_LIMIT);
    assign clear_hit = wr_any && (cmd_code == CMD_CLEAR_FAULTS);
    assign known_cmd = (|lim_hit) || (cmd_code == CMD_CLEAR_FAULTS)
        || (!cmd_write && (cmd_code == CMD_STATUS_WORD || cmd_code == CMD_STATUS_VOUT
        || cmd_code == CMD_STATUS_CML));

    ////////////////////////////////////////////////////////////////////////
    // mapping base: 1.0 in relative mode, the present target in absolute; the fault limit always maps against the target
    logic [15:0] map_base;
    logic [15:0] map_base_uvf;
    assign map_base = vout_mode_relative ? REL_ONE : vout_target;
    assign map_base_uvf = vout_target;

    ////////////////////////////////////////////////////////////////////////
    // per-limit mapper, store and step; nvm restore takes the mapper's input
    localparam int MIN_TAB [NUM_LIMITS] = '{OVW_MIN, UVW_MIN, UVF_MIN};
    localparam int MAX_TAB [NUM_LIMITS] = '{OVW_MAX, UVW_MAX, UVF_MAX};
    localparam int STEP_TAB [NUM_LIMITS] = '{OVW_STEP, UVW_STEP, UVF_STEP};
    localparam bit UP_TAB [NUM_LIMITS] = '{1'b1, 1'b0, 1'b0};
    logic [15:0] nvm_word [NUM_LIMITS];
    logic [NUM_LIMITS-1:0] map_ok;
    logic [NUM_LIMITS-1:0] wr_hit;
    logic [NUM_LIMITS-1:0] bad_write;
    assign nvm_word[IDX_OVW] = nvm_ov_warn_value;
    assign nvm_word[IDX_UVW] = nvm_uv_warn_value;
    assign nvm_word[IDX_UVF] = nvm_uv_fault_value;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_LIMITS; gi++) begin : g_lim
            logic [15:0] map_in;
            logic [STEP_W-1:0] map_step;
            logic load_ok;
            assign map_in = nvm_load ? nvm_word[gi] : cmd_wdata;
            assign wr_hit[gi] = wr_any && lim_hit[gi] && !nvm_load;
            assign bad_write[gi] = wr_hit[gi] && !map_ok[gi];
            assign load_ok = map_ok[gi] && (nvm_load || wr_hit[gi]);

            limit_step_mapper #(
                .MIN_S(MIN_TAB[gi]),
                .MAX_S(MAX_TAB[gi]),
                .STEP_S(STEP_TAB[gi]),
                .ROUND_UP(UP_TAB[gi])
            ) u_map (
                .value(map_in),
                .base(gi == IDX_UVF ? map_base_uvf : map_base),
                .step_out(map_step),
                .ok(map_ok[gi])
            );

            // raw word is kept as written; target changes never touch it
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    limit_reg[gi] <= LIMIT_RESET;
                    step_reg[gi] <= STEP_RESET;
                end else if (load_ok) begin
                    limit_reg[gi] <= map_in;
                    step_reg[gi] <= map_step;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // comparators: sense*scale against step*target, so no divider is needed
    logic [31:0] sense_scaled;
    logic [31:0] ovw_level;
    logic [31:0] uvw_level;
    logic [31:0] uvf_level;
    logic ovw_cond;
    logic uvw_cond;
    logic uvf_cond;
    assign sense_scaled = 32'(vout_sense) * PCT_SCALE;
    assign ovw_level = 32'(step_reg[IDX_OVW]) * 32'(vout_target);
    assign uvw_level = 32'(step_reg[IDX_UVW]) * 32'(vout_target);
    assign uvf_level = 32'(step_reg[IDX_UVF]) * 32'(vout_target);
    assign ovw_cond = armed_reg && (sense_scaled > ovw_level);
    assign uvw_cond = armed_reg && (sense_scaled < uvw_level);
    assign uvf_cond = armed_reg && (sense_scaled < uvf_level);

    ////////////////////////////////////////////////////////////////////////
    // sticky status: a set in the clearing cycle wins over the clear
    always_comb begin
        status_vout_next = clear_hit ? STATUS_RESET : status_vout_reg;
        status_vout_next[STATUS_OV_WARN_VALUE_BIT] = status_vout_next[STATUS_OV_WARN_VALUE_BIT]
            | ovw_cond;
        status_vout_next[STATUS_UV_WARN_VALUE_BIT] = status_vout_next[STATUS_UV_WARN_VALUE_BIT]
            | uvw_cond;
        status_cml_next = clear_hit ? STATUS_RESET : status_cml_reg;
        status_cml_next[STATUS_CML_BAD_DATA_BIT] = status_cml_next[STATUS_CML_BAD_DATA_BIT]
            | (|bad_write);
        status_cml_next[STATUS_CML_BAD_CMD_BIT] = status_cml_next[STATUS_CML_BAD_CMD_BIT]
            | (cmd_valid && !known_cmd && !nvm_load);
    end

    // status word view assembled from the two status bytes
    logic [15:0] status_word;
    always_comb begin
        status_word = 16'h0000;
        status_word[STATUS_WORD_VOUT_BIT] = |status_vout_reg;
        status_word[STATUS_WORD_CML_BIT] = |status_cml_reg;
    end

    // read mux; unknown codes return zero
    logic [15:0] rd_mux;
    assign rd_mux = lim_hit[IDX_OVW] ? limit_reg[IDX_OVW]
        : lim_hit[IDX_UVW] ? limit_reg[IDX_UVW]
        : lim_hit[IDX_UVF] ? limit_reg[IDX_UVF]
        : (cmd_code == CMD_STATUS_WORD) ? status_word
        : (cmd_code == CMD_STATUS_VOUT) ? {8'h00, status_vout_reg}
        : (cmd_code == CMD_STATUS_CML) ? {8'h00, status_cml_reg}
        : 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // monitor arms once limits are restored, so zero steps never trip
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
        end else if (nvm_load) begin
            armed_reg <= 1'b1;
        end
    end

    // status registers and alert, which stays low while anything is flagged
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_vout_reg <= STATUS_RESET;
            status_cml_reg <= STATUS_RESET;
            alert_n_reg <= 1'b1;
        end else begin
            status_vout_reg <= status_vout_next;
            status_cml_reg <= status_cml_next;
            alert_n_reg <= !((|status_vout_next) || (|status_cml_next));
        end
    end

    // fault level handed to the response logic, plus its onset pulse
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            uv_fault_reg <= 1'b0;
        end else begin
            uv_fault_reg <= uvf_cond;
        end
    end
    assign uv_fault = uv_fault_reg;
    assign uv_fault_event = uvf_cond && !uv_fault_reg;

    // read answer one cycle after the request
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_any;
            if (rd_any) begin
                rd_data_reg <= rd_mux;
            end
        end
    end
    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign alert_n = alert_n_reg;
endmodule : vout_limit_monitor

// ---- hw/vout_limit_pkg.sv ----
// constants shared by the output-voltage limit monitor and its step mapper
package vout_limit_pkg;
    // command codes of the limit registers
    localparam logic [7:0] CMD_OVERVOLTAGE_WARNING_LIMIT = 8'h42;
    localparam logic [7:0] CMD_UV_WARN_LIMIT = 8'h43;
    localparam logic [7:0] CMD_UV_FAULT_LIMIT = 8'h44;
    // status access and clearing codes
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
    localparam logic [7:0] CMD_STATUS_VOUT = 8'h7a;
    localparam logic [7:0] CMD_STATUS_CML = 8'h7e;
    // field positions in the status registers
    localparam int STATUS_WORD_VOUT_BIT = 15;
    localparam int STATUS_WORD_CML_BIT = 1;
    localparam int STATUS_OV_WARN_VALUE_BIT = 6;
    localparam int STATUS_UV_WARN_VALUE_BIT = 5;
    localparam int STATUS_UV_FAULT_VALUE_BIT = 4;
    localparam int STATUS_CML_BAD_CMD_BIT = 7;
    localparam int STATUS_CML_BAD_DATA_BIT = 6;
    // reset values
    localparam logic [15:0] LIMIT_RESET = 16'h0000;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] STEP_RESET = 8'h00;
    // thresholds in half-percent units: value*SCALE compared to step*base
    localparam int STEP_W = 8;
    localparam logic [31:0] PCT_SCALE = 32'd200;
    localparam logic [15:0] REL_ONE = 16'h0200; // 1.0 in relative format
    localparam int OVW_MIN = 206; // 103 %
    localparam int OVW_MAX = 232; // 116 %
    localparam int OVW_STEP = 2; // 1 %
    localparam int UVW_MIN = 168; // 84 %
    localparam int UVW_MAX = 194; // 97 %
    localparam int UVW_STEP = 2; // 1 %
    localparam int UVF_MIN = 120; // 60 %
    localparam int UVF_MAX = 190; // 95 %
    localparam int UVF_STEP = 5; // 2.5 %
    localparam int NUM_LIMITS = 3;
    localparam int IDX_OVW = 0;
    localparam int IDX_UVW = 1;
    localparam int IDX_UVF = 2;
endpackage : vout_limit_pkg

// ---- verif/pmbus_host_model.sv ----
// host model issuing word writes and reads on the command port
`timescale 1ns/1ps
module pmbus_host_model (
    input wire logic clk,
    output logic cmd_valid = 1'b0,
    output logic cmd_write = 1'b0,
    output logic [7:0] cmd_code = 8'h00,
    output logic [15:0] cmd_wdata = 16'h0000,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid
);
    // one whole word per command; gap idles a slow host before it asks
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
            input int gap, output logic [15:0] q);
        int n;
        repeat (gap + 1) begin
            @(posedge clk);
            #1;
        end
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        cmd_wdata = data;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        cmd_wdata = ~data; // a released word must not keep looking valid
        n = 0;
        while (!wr && rd_valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        q = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
    endtask : xfer
endmodule : pmbus_host_model

// ---- verif/vout_limit_monitor_asserts.sv ----
// concurrent checks on the limit monitor ports
`timescale 1ns/1ps
module vout_limit_monitor_asserts (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] rd_data,
    input wire logic rd_valid,
    input wire logic nvm_load,
    input wire logic uv_fault,
    input wire logic uv_fault_event,
    input wire logic alert_n
);
    import vout_limit_pkg::*;
    logic armed_reg, rd_req, clr_req, known;
    // reads and clears are served even while a restore is pulsed; limit writes and bad-command flagging yield
    assign rd_req = cmd_valid && !cmd_write;
    assign clr_req = cmd_valid && cmd_write && cmd_code == CMD_CLEAR_FAULTS;
    assign known = cmd_code inside {CMD_OVERVOLTAGE_WARNING_LIMIT, CMD_UV_WARN_LIMIT, CMD_UV_FAULT_LIMIT,
        CMD_CLEAR_FAULTS, CMD_STATUS_WORD, CMD_STATUS_VOUT, CMD_STATUS_CML};
    // the monitor stays blind until the first restore
    always_ff @(posedge clk) armed_reg <= rst_n && (armed_reg || nvm_load);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    property p_rd_answer; rd_req |=> rd_valid; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    property p_rd_only; !rd_req |=> !rd_valid; endproperty
    a_rd_only: assert property (p_rd_only) else $error("answer without read");
    property p_rd_hold; !rd_valid && $past(rst_n) |-> $stable(rd_data); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_unk_read; rd_req && !known |=> rd_data == 16'h0000; endproperty
    a_unk_read: assert property (p_unk_read) else $error("unknown read not zero");
    property p_bad_cmd; cmd_valid && !nvm_load && !known |-> ##[1:2] !alert_n; endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("bad command not alerted");
    property p_fault_level; uv_fault_event |=> uv_fault; endproperty
    a_fault_level: assert property (p_fault_level) else $error("fault level missing");
    property p_fault_rise; $rose(uv_fault) && $past(rst_n) |-> $past(uv_fault_event); endproperty
    a_fault_rise: assert property (p_fault_rise) else $error("fault without onset");
    property p_disarmed; !armed_reg |-> !uv_fault && !uv_fault_event; endproperty
    a_disarmed: assert property (p_disarmed) else $error("fault while disarmed");
    // alert may only return high through a clear, one to three cycles after it
    property p_alert_clear; $rose(alert_n) && $past(rst_n) |->
        $past(clr_req) || $past(clr_req, 2) || $past(clr_req, 3); endproperty
    a_alert_clear: assert property (p_alert_clear) else $error("alert dropped alone");
endmodule : vout_limit_monitor_asserts
bind vout_limit_monitor vout_limit_monitor_asserts i_vout_limit_monitor_asserts (.clk(clk),
    .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .rd_data(rd_data), .rd_valid(rd_valid), .nvm_load(nvm_load), .uv_fault(uv_fault),
    .uv_fault_event(uv_fault_event), .alert_n(alert_n));

// ---- verif/vout_limit_monitor_tb.sv ----
// self-checking bench for the output-voltage limit monitor
`timescale 1ns/1ps
module vout_limit_monitor_tb;
    import vout_limit_pkg::*;
    logic clk, rst_n, cmd_valid, cmd_write, rd_valid, nvm_load, mode_rel;
    logic uv_fault, uv_fault_event, alert_n;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, rd_data, nvm_ov, nvm_uv, nvm_uf, target, sense;
    int err_total = 0;
    int cmp_count = 0;
    int ev_cnt = 0;
    // design and the host on its command port
    vout_limit_monitor i_vout_limit_monitor (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data),
        .rd_valid(rd_valid), .nvm_load(nvm_load), .nvm_ov_warn_value(nvm_ov),
        .nvm_uv_warn_value(nvm_uv), .nvm_uv_fault_value(nvm_uf), .vout_mode_relative(mode_rel),
        .vout_target(target), .vout_sense(sense), .uv_fault(uv_fault),
        .uv_fault_event(uv_fault_event), .alert_n(alert_n));
    pmbus_host_model i_pmbus_host_model (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid));
    // clock, and a tally of fault onset pulses
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) ev_cnt <= ev_cnt + int'(uv_fault_event === 1'b1);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
        logic [15:0] q;
        i_pmbus_host_model.xfer(1'b0, code, 16'h0000, 1, q);
        chk(q, exp);
    endtask : rdchk
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        logic [15:0] q;
        i_pmbus_host_model.xfer(1'b1, code, data, 0, q);
    endtask : wr
    // sense moves, then status and the registered alert get time to settle
    task automatic setv(input logic [15:0] v);
        sense = v;
        repeat (3) @(posedge clk);
        #1;
    endtask : setv
    task automatic alert_is(input logic a);
        chk({15'h0000, alert_n}, {15'h0000, a});
    endtask : alert_is
    task automatic clear;
        wr(CMD_CLEAR_FAULTS, 16'h0000);
        setv(sense);
        alert_is(1'b1);
        rdchk(CMD_STATUS_VOUT, 16'h0000);
    endtask : clear
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_restore;
        rdchk(CMD_UV_FAULT_LIMIT, LIMIT_RESET);
        nvm_load = 1'b1;
        @(posedge clk);
        #1;
        nvm_load = 1'b0;
        rdchk(CMD_OVERVOLTAGE_WARNING_LIMIT, 16'h0210);
        rdchk(CMD_UV_WARN_LIMIT, 16'h01cd);
        rdchk(CMD_UV_FAULT_LIMIT, 16'd705);
        alert_is(1'b1);
        $display("test restore done");
    endtask : t_restore
    // over 104 %, under 90 %, fault under 70 % of a target of 1000
    task automatic t_levels;
        int n;
        setv(16'd1040);
        alert_is(1'b1);
        setv(16'd1041);
        alert_is(1'b0);
        setv(16'd1000);
        rdchk(CMD_STATUS_WORD, 16'h8000);
        rdchk(CMD_STATUS_VOUT, 16'h0040);
        clear();
        setv(16'd900);
        alert_is(1'b1);
        setv(16'd899);
        rdchk(CMD_STATUS_VOUT, 16'h0020);
        setv(16'd700);
        chk({15'h0000, uv_fault}, 16'h0000);
        n = ev_cnt;
        setv(16'd699);
        chk({15'h0000, uv_fault}, 16'h0001);
        chk(16'(ev_cnt - n), 16'h0001);
        setv(16'd1000);
        clear();
        $display("test levels done");
    endtask : t_levels
    // target doubles: stored words stay, levels follow
    task automatic t_track;
        target = 16'd2000;
        setv(16'd2080);
        rdchk(CMD_OVERVOLTAGE_WARNING_LIMIT, 16'h0210);
        alert_is(1'b1);
        setv(16'd1399);
        chk({15'h0000, uv_fault}, 16'h0001);
        target = 16'd1000;
        setv(16'd1000);
        clear();
        $display("test track done");
    endtask : t_track
    task automatic t_bad;
        wr(CMD_OVERVOLTAGE_WARNING_LIMIT, 16'h0400); // twice the target is out of range
        rdchk(CMD_OVERVOLTAGE_WARNING_LIMIT, 16'h0210);
        rdchk(CMD_STATUS_CML, 16'h0040);
        rdchk(CMD_STATUS_WORD, 16'h0002);
        alert_is(1'b0);
        clear();
        wr(CMD_UV_FAULT_LIMIT, 16'd100); // ten percent is below the range
        rdchk(CMD_STATUS_CML, 16'h0040);
        clear();
        rdchk(8'h55, 16'h0000);
        rdchk(CMD_STATUS_CML, 16'h0080);
        clear();
        $display("test invalid done");
    endtask : t_bad
    // 1.0625 rounds up to 107 %, then 104 % acts at once
    task automatic t_live;
        wr(CMD_OVERVOLTAGE_WARNING_LIMIT, 16'h0220);
        setv(16'd1065);
        alert_is(1'b1);
        wr(CMD_OVERVOLTAGE_WARNING_LIMIT, 16'h0210);
        setv(16'd1065);
        alert_is(1'b0);
        setv(16'd1000);
        clear();
        mode_rel = 1'b0;
        wr(CMD_UV_WARN_LIMIT, 16'd905);
        rdchk(CMD_UV_WARN_LIMIT, 16'd905);
        // absolute mode: target doubles, the word stays and 90 % follows it
        target = 16'd2000;
        setv(16'd1790);
        rdchk(CMD_UV_WARN_LIMIT, 16'd905);
        alert_is(1'b0);
        target = 16'd1000;
        setv(16'd1000);
        clear();
        $display("test live update done");
    endtask : t_live
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        nvm_load = 1'b0;
        mode_rel = 1'b1;
        nvm_ov = 16'h0210; // 1.031 rounds up to 104 %
        nvm_uv = 16'h01cd; // 0.900 rounds down to 90 %
        nvm_uf = 16'd705; // 70.5 % of 1000 rounds down to 70 %
        target = 16'd1000;
        sense = 16'd1000;
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_restore();
        t_levels();
        t_track();
        t_bad();
        t_live();
        complete_run();
    end
    // watchdog far beyond the fewer than two hundred cycles the tests take
    initial begin
        #100000;
        err_total++;
        complete_run();
    end
endmodule : vout_limit_monitor_tb
